// [src/sfc_pkg.sv]
package sfc_pkg;
    // ------------------------------------------------------------
    // array and address geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 18;
    localparam int MEM_BYTES = 262144;
    localparam int PAGE_BYTES = 256;
    localparam logic [17:0] ADDR_ONE = 18'h00001;
    localparam logic [18:0] LEN_SMALL_SECTOR = 19'h01000;
    localparam logic [18:0] LEN_SECTOR = 19'h10000;
    localparam logic [18:0] LEN_CHIP = 19'h40000;
    localparam logic [18:0] LEN_PAGE = 19'h00100;
    localparam logic [18:0] LEN_STATUS_WRITE = 19'h00010;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_NONE = 8'h00;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0b;
    localparam logic [7:0] OP_SMALL_ERASE_A = 8'hd7;
    localparam logic [7:0] OP_SMALL_ERASE_B = 8'h20;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE = 8'hc7;
    localparam logic [7:0] OP_PROGRAM = 8'h02;
    localparam logic [7:0] OP_WRITE_EN = 8'h06;
    localparam logic [7:0] OP_WRITE_DIS = 8'h04;
    localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_READ_ID = 8'h9f;
    localparam logic [7:0] OP_ID_WAKE = 8'hab;

    // ------------------------------------------------------------
    // status byte layout
    // ------------------------------------------------------------
    localparam int ST_BUSY = 0;
    localparam int ST_WEL = 1;
    localparam int ST_PROT_LO = 2;
    localparam int ST_PROT_HI = 3;
    localparam int ST_LOCK = 7;
    localparam logic [2:0] NV_STATUS_RESET = 3'h0;

    // identification bytes: arbitrary neutral values
    localparam logic [7:0] ID_MAKER = 8'h5a;
    localparam logic [7:0] ID_TYPE = 8'h01;
    localparam logic [7:0] ID_SIZE = 8'h12;
    localparam logic [7:0] ID_SECOND = 8'h3c;

    // ------------------------------------------------------------
    // host controller timing and registers
    // ------------------------------------------------------------
    localparam int MCLK_NS = 8;
    localparam int SCK_HALF_NS = 80;
    localparam logic [7:0] SCK_HALF_CYC = 8'((SCK_HALF_NS + MCLK_NS - 1) / MCLK_NS);
    localparam logic [3:0] REG_DATA = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_RX = 4'h8;
    localparam logic [3:0] REG_PINS = 4'hc;
    localparam int DATA_LAST_BIT = 8;
    localparam int PINS_WP = 0;
    localparam int PINS_HOLD = 1;
    localparam logic [1:0] PINS_RESET = 2'h3;

    typedef enum logic [1:0] {SFC_W_ERASE, SFC_W_PROG, SFC_W_STATUS} sfc_walk_t;
endpackage

// [src/sfc_link_if.sv]
`timescale 1ns/1ps
// so is driven by the device at all times; so_oe only marks when its value is valid
interface sfc_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    logic wp_n;
    logic hold_n;
    modport device (input cs_n, input sck, input si, input wp_n, input hold_n,
                    output so, output so_oe);
    modport host (output cs_n, output sck, output si, output wp_n, output hold_n,
                  input so);
endinterface

// [src/sfc_sync.sv]
`timescale 1ns/1ps
module sfc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    // meta_q feeds q_o alone
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_q <= RST;
            q_o <= RST;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

// [src/sfc_device.sv]
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// Notes on behaviour
// R1: active only while select is low
// R2: input bits taken on clock rising edges
// R3: output bit advances on clock falling edges
// R4: bytes travel most significant bit first
// R5: output driven only for read, status, id
// R6: clock level at select fall picks mode
// R7: status lock honoured only while protect low
// R8: hold low freezes transfer, keeps its place
// R9: 03h, three address bytes, then data out
// R10: 0Bh, address, one dummy, then data out
// R11: D7h or 20h erases 4 KB sector
// R12: D8h erases 64 KB; C7h whole chip
// R13: 02h, address, then page data bytes
// R14: 06h sets, 04h clears write enable
// R15: B9h powers down, ABh wakes up
// R16: 05h reads status; 01h writes status
// R17: 9Fh ids now; ABh plus three gives second
// R18: address bits 23 to 18 are ignored
// R19: non-read commands act at select rise only
// R20: read address increments, wraps to zero
// R21: status repeats each byte, allowed while busy
// R22: status bit 0 set while write busy
// R23: partial command dropped when select rises early
module sfc_device (
    input wire logic mclk_i,
    input wire logic resetn_i,
    sfc_link_if.device link,
    output logic busy_o,
    output logic wel_o,
    output logic power_down_o,
    output logic mode3_o
);
    import sfc_pkg::*;

    // ------------------------------------------------------------
    // pin sampling and edge finding
    // ------------------------------------------------------------
    logic cs_n_s, sck_s, si_s, wp_n_s, hold_n_s;
    logic sck_prev_q, cs_prev_q;

    // reset to idle pin levels: no false select edge after reset
    sfc_sync #(.W(5), .RST(5'h13)) u_sync (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .d_i({link.cs_n, link.sck, link.si, link.wp_n, link.hold_n}),
        .q_o({cs_n_s, sck_s, si_s, wp_n_s, hold_n_s})
    );

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sck_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= sck_s;
            cs_prev_q <= cs_n_s;
        end
    end

    logic sel, rise, fall, cs_fall, cs_rise;
    assign sel = !cs_n_s; // [R1]
    assign rise = sel && hold_n_s && sck_s && !sck_prev_q; // [R2] [R8]
    assign fall = sel && hold_n_s && !sck_s && sck_prev_q; // [R3] [R8]
    assign cs_fall = cs_prev_q && !cs_n_s;
    assign cs_rise = !cs_prev_q && cs_n_s;

    // ------------------------------------------------------------
    // state declarations
    // ------------------------------------------------------------
    logic [7:0] mem [MEM_BYTES];
    logic [7:0] page_buf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] page_vld_q;
    logic [6:0] sh_q;
    logic [2:0] bit_q, cnt_q;
    logic [7:0] op_q, tx_q, tx_nxt, stw_q;
    logic [17:0] addr_q, addr_nxt, addr_shift, rd_addr;
    logic sending_q, send_nxt, drive_q, so_q, so_oe_q;
    logic busy_q, wel_q, pd_q, mode3_q;
    logic [2:0] nv_q; // lock, protect high, protect low
    logic [17:0] walk_addr_q, walk_base;
    logic [18:0] walk_left_q, walk_len;
    sfc_walk_t walk_kind_q, walk_kind;
    logic start_walk, commit, op_ok, walk_last;
    logic [7:0] rx_byte, status;

    assign rx_byte = {sh_q, si_s}; // [R4]
    assign addr_shift = {addr_q[9:0], rx_byte}; // [R18]
    assign status = {nv_q[2], 3'h0, nv_q[1:0], wel_q, busy_q}; // [R22]
    assign op_ok = pd_q ? (rx_byte == OP_ID_WAKE) : (!busy_q || rx_byte == OP_READ_STATUS);
    assign walk_last = busy_q && walk_left_q == 19'h00001;

    function automatic logic [7:0] id_byte(input logic [1:0] idx);
        unique case (idx)
            2'd0: id_byte = ID_MAKER;
            2'd1: id_byte = ID_TYPE;
            default: id_byte = ID_SIZE;
        endcase
    endfunction

    // bytes a command needs before select rises; 0 marks a read-type command
    function automatic logic [2:0] cmd_len(input logic [7:0] op);
        unique case (op)
            OP_SMALL_ERASE_A, OP_SMALL_ERASE_B, OP_SECTOR_ERASE: cmd_len = 3'd4;
            OP_CHIP_ERASE, OP_WRITE_EN, OP_WRITE_DIS, OP_POWER_DOWN, OP_ID_WAKE: cmd_len = 3'd1;
            OP_WRITE_STATUS: cmd_len = 3'd2;
            OP_PROGRAM: cmd_len = 3'd5;
            default: cmd_len = 3'd0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // bit and byte position
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sh_q <= '0;
            bit_q <= '0;
            cnt_q <= '0;
        end else if (!sel) begin
            bit_q <= '0; // [R23]
            cnt_q <= '0;
        end else if (rise) begin
            sh_q <= rx_byte[6:0];
            bit_q <= bit_q + 3'd1;
            if (bit_q == 3'd7 && cnt_q != 3'd7) begin
                cnt_q <= cnt_q + 3'd1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            op_q <= OP_NONE;
        end else if (rise && bit_q == 3'd7 && cnt_q == 3'd0) begin
            op_q <= op_ok ? rx_byte : OP_NONE;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode3_q <= 1'b0;
        end else if (cs_fall) begin
            mode3_q <= sck_s; // [R6]
        end
    end

    // ------------------------------------------------------------
    // next output byte and address at each byte boundary
    // ------------------------------------------------------------
    always_comb begin
        send_nxt = 1'b0;
        tx_nxt = tx_q;
        addr_nxt = addr_q;
        rd_addr = (cnt_q == 3'd3) ? addr_shift : addr_q;
        if (cnt_q == 3'd0) begin
            send_nxt = op_ok && (rx_byte == OP_READ_STATUS || rx_byte == OP_READ_ID); // [R17]
            tx_nxt = (rx_byte == OP_READ_ID) ? id_byte(2'd0) : status; // [R16]
            addr_nxt = ADDR_ONE;
        end else begin
            if (cnt_q <= 3'd3) begin
                addr_nxt = addr_shift; // [R9]
            end
            unique case (op_q)
                OP_READ, OP_FAST_READ: begin
                    if (cnt_q >= ((op_q == OP_READ) ? 3'd3 : 3'd4)) begin // [R9] [R10]
                        send_nxt = 1'b1;
                        tx_nxt = mem[rd_addr];
                        addr_nxt = rd_addr + ADDR_ONE; // [R20]
                    end
                end
                OP_READ_STATUS: begin
                    send_nxt = 1'b1;
                    tx_nxt = status; // [R21]
                end
                OP_READ_ID: begin
                    send_nxt = 1'b1;
                    tx_nxt = id_byte(addr_q[1:0]);
                    addr_nxt = (addr_q[1:0] == 2'd2) ? '0 : addr_q + ADDR_ONE;
                end
                OP_ID_WAKE: begin
                    send_nxt = cnt_q >= 3'd3;
                    tx_nxt = ID_SECOND; // [R17]
                end
                OP_PROGRAM: begin
                    if (cnt_q >= 3'd4) begin
                        addr_nxt = {addr_q[17:8], addr_q[7:0] + 8'h01}; // [R13]
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            addr_q <= '0;
            tx_q <= '0;
            sending_q <= 1'b0;
        end else if (!sel) begin
            sending_q <= 1'b0;
        end else if (rise && bit_q == 3'd7) begin
            addr_q <= addr_nxt;
            tx_q <= tx_nxt;
            sending_q <= send_nxt;
        end
    end

    // ------------------------------------------------------------
    // serial output: quiet while shifting in, released on deselect
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            so_q <= 1'b0;
            drive_q <= 1'b0;
            so_oe_q <= 1'b0;
        end else begin
            if (!sel) begin
                drive_q <= 1'b0; // [R5]
            end else if (fall && sending_q) begin
                so_q <= tx_q[3'd7 - bit_q]; // [R3] [R4]
                drive_q <= 1'b1;
            end
            so_oe_q <= sel && drive_q && hold_n_s; // [R5] [R8]
        end
    end

    // ------------------------------------------------------------
    // page data and status write data
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rise && bit_q == 3'd7 && op_q == OP_PROGRAM && cnt_q >= 3'd4) begin
            page_buf[addr_q[7:0]] <= rx_byte; // [R13]
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            page_vld_q <= '0;
            stw_q <= '0;
        end else if (cs_fall && !busy_q) begin
            page_vld_q <= '0;
        end else if (rise && bit_q == 3'd7) begin
            if (op_q == OP_PROGRAM && cnt_q >= 3'd4) begin
                page_vld_q[addr_q[7:0]] <= 1'b1;
            end
            if (op_q == OP_WRITE_STATUS && cnt_q == 3'd1) begin
                stw_q <= rx_byte; // [R16]
            end
        end
    end

    // ------------------------------------------------------------
    // commit at select rise and the internal write walker
    // ------------------------------------------------------------
    // only whole commands on a byte boundary get here; reads never commit
    assign commit = cs_rise && bit_q == 3'd0 && cmd_len(op_q) != 3'd0 &&
                    ((op_q == OP_PROGRAM) ? cnt_q >= 3'd5 : cnt_q == cmd_len(op_q)); // [R19] [R23]

    always_comb begin
        start_walk = commit && wel_q;
        walk_base = '0;
        walk_len = LEN_CHIP; // [R12]
        walk_kind = SFC_W_ERASE;
        unique case (op_q)
            OP_SMALL_ERASE_A, OP_SMALL_ERASE_B: begin
                walk_base = {addr_q[17:12], 12'h000}; // [R11]
                walk_len = LEN_SMALL_SECTOR;
            end
            OP_SECTOR_ERASE: begin
                walk_base = {addr_q[17:16], 16'h0000}; // [R12]
                walk_len = LEN_SECTOR;
            end
            OP_PROGRAM: begin
                walk_base = {addr_q[17:8], 8'h00};
                walk_len = LEN_PAGE;
                walk_kind = SFC_W_PROG;
            end
            OP_WRITE_STATUS: begin
                walk_len = LEN_STATUS_WRITE;
                walk_kind = SFC_W_STATUS;
                start_walk = commit && wel_q && !(nv_q[2] && !wp_n_s); // [R7]
            end
            OP_CHIP_ERASE: begin
            end
            default: start_walk = 1'b0;
        endcase
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_q <= 1'b0;
            walk_addr_q <= '0;
            walk_left_q <= '0;
            walk_kind_q <= SFC_W_ERASE;
        end else if (start_walk) begin
            busy_q <= 1'b1; // [R22]
            walk_addr_q <= walk_base;
            walk_left_q <= walk_len;
            walk_kind_q <= walk_kind;
        end else if (busy_q) begin
            walk_addr_q <= walk_addr_q + ADDR_ONE;
            walk_left_q <= walk_left_q - 19'h00001;
            busy_q <= !walk_last; // [R22]
        end
    end

    // one byte per clock; flash programming can only clear bits
    always_ff @(posedge mclk_i) begin
        if (busy_q && walk_kind_q == SFC_W_ERASE) begin
            mem[walk_addr_q] <= ERASED_BYTE;
        end else if (busy_q && walk_kind_q == SFC_W_PROG && page_vld_q[walk_addr_q[7:0]]) begin
            mem[walk_addr_q] <= mem[walk_addr_q] & page_buf[walk_addr_q[7:0]];
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            nv_q <= NV_STATUS_RESET;
        end else if (walk_last && walk_kind_q == SFC_W_STATUS) begin
            nv_q <= {stw_q[ST_LOCK], stw_q[ST_PROT_HI], stw_q[ST_PROT_LO]};
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wel_q <= 1'b0;
            pd_q <= 1'b0;
        end else if (commit) begin
            if (op_q == OP_WRITE_EN) begin
                wel_q <= 1'b1; // [R14]
            end else if (op_q == OP_WRITE_DIS || start_walk) begin
                wel_q <= 1'b0; // [R14]
            end
            if (op_q == OP_POWER_DOWN) begin
                pd_q <= 1'b1; // [R15]
            end else if (op_q == OP_ID_WAKE) begin
                pd_q <= 1'b0; // [R15]
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign link.so = so_q;
    assign link.so_oe = so_oe_q;
    assign busy_o = busy_q;
    assign wel_o = wel_q;
    assign power_down_o = pd_q;
    assign mode3_o = mode3_q;
endmodule

// [src/sfc_host.sv]
`timescale 1ns/1ps
module sfc_host (
    input wire logic mclk_i,
    input wire logic resetn_i,
    sfc_link_if.host link,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o
);
    import sfc_pkg::*;

    typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_END} sfc_host_state_t;

    sfc_host_state_t state_q;
    logic cs_n_q, sck_q, si_q, last_q, so_s;
    logic [7:0] tx_q, rx_q, tmr_q;
    logic [2:0] bit_q;
    logic [1:0] pins_q;
    logic start;

    sfc_sync #(.W(1)) u_sync (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .d_i(link.so),
        .q_o(so_s)
    );

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    // a data write while a byte is in flight is dropped
    assign start = wr_i && addr_i == REG_DATA && state_q == H_IDLE;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_q <= '0;
            last_q <= 1'b0;
            pins_q <= PINS_RESET;
        end else if (start) begin
            tx_q <= wdata_i[7:0];
            last_q <= wdata_i[DATA_LAST_BIT];
        end else if (wr_i && addr_i == REG_PINS) begin
            pins_q <= wdata_i[1:0];
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            unique case (addr_i)
                REG_DATA: rdata_o <= {23'h0, last_q, tx_q};
                REG_STATUS: rdata_o <= {30'h0, !cs_n_q, state_q != H_IDLE};
                REG_RX: rdata_o <= {24'h0, rx_q};
                REG_PINS: rdata_o <= {30'h0, pins_q};
                default: rdata_o <= '0;
            endcase
        end else begin
            rdata_o <= '0;
        end
    end

    // ------------------------------------------------------------
    // mode 0 byte engine; select stays low between bytes until last
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= H_IDLE;
            cs_n_q <= 1'b1;
            sck_q <= 1'b0;
            si_q <= 1'b0;
            bit_q <= '0;
            tmr_q <= '0;
            rx_q <= '0;
        end else begin
            unique case (state_q)
                H_IDLE: begin
                    if (start) begin
                        cs_n_q <= 1'b0; // [R1]
                        si_q <= wdata_i[7]; // [R4]
                        bit_q <= '0;
                        tmr_q <= SCK_HALF_CYC - 8'h01;
                        state_q <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (tmr_q == 8'h00) begin
                        sck_q <= 1'b1; // [R2]
                        rx_q <= {rx_q[6:0], so_s}; // [R4]
                        tmr_q <= SCK_HALF_CYC - 8'h01;
                        state_q <= H_HIGH;
                    end else begin
                        tmr_q <= tmr_q - 8'h01;
                    end
                end
                H_HIGH: begin
                    if (tmr_q != 8'h00) begin
                        tmr_q <= tmr_q - 8'h01;
                    end else begin
                        sck_q <= 1'b0;
                        tmr_q <= SCK_HALF_CYC - 8'h01;
                        if (bit_q != 3'd7) begin
                            bit_q <= bit_q + 3'd1;
                            si_q <= tx_q[3'd6 - bit_q]; // [R4]
                            state_q <= H_LOW;
                        end else begin
                            state_q <= last_q ? H_END : H_IDLE;
                        end
                    end
                end
                H_END: begin
                    if (tmr_q == 8'h00) begin
                        cs_n_q <= 1'b1; // [R19]
                        state_q <= H_IDLE;
                    end else begin
                        tmr_q <= tmr_q - 8'h01;
                    end
                end
            endcase
        end
    end

    assign link.cs_n = cs_n_q;
    assign link.sck = sck_q;
    assign link.si = si_q;
    assign link.wp_n = pins_q[PINS_WP];
    assign link.hold_n = pins_q[PINS_HOLD];
endmodule

// [dv/sfc_chk.sv]
`timescale 1ns/1ps
// ----------------
// link checker
// ----------------
module sfc_chk (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe,
    input wire logic hold_n
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_desel; cs_n [*5]; endsequence
    sequence s_held; !hold_n [*5]; endsequence
    property p_desel; s_desel |-> !so_oe; endproperty
    a_desel: assert property (p_desel) else $error("so driven while deselected");
    property p_hold; s_held |-> !so_oe; endproperty
    a_hold: assert property (p_hold) else $error("so driven during hold");
    property p_fall; so_oe && $changed(so) |-> !sck; endproperty
    a_fall: assert property (p_fall) else $error("so moved with clock high");
    property p_steady; so_oe && sck |-> $stable(so); endproperty
    a_steady: assert property (p_steady) else $error("so unstable in high phase");
    property p_oe; $rose(so_oe) |-> !cs_n && !sck; endproperty
    a_oe: assert property (p_oe) else $error("output enabled at wrong moment");
    property p_idle; cs_n |-> !sck; endproperty
    a_idle: assert property (p_idle) else $error("clock not low while idle");
    property p_si; !cs_n && sck |-> $stable(si); endproperty
    a_si: assert property (p_si) else $error("si moved in high phase");
    property p_hi; $rose(sck) |-> sck [*8]; endproperty
    a_hi: assert property (p_hi) else $error("clock high phase short");
endmodule

// [dv/serial_flash_command_port_tb_top.sv]
`timescale 1ns/1ps
module serial_flash_command_port_tb_top;
    import sfc_pkg::*;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic busy, wel, pdown, mode3;
    logic [7:0] rx;
    int n_mismatch = 0;
    int samples_checked = 0;
    sfc_link_if sfc_link_if_i ();
    sfc_host sfc_host_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .link(sfc_link_if_i.host),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
    sfc_device sfc_device_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .link(sfc_link_if_i.device),
        .busy_o(busy), .wel_o(wel), .power_down_o(pdown), .mode3_o(mode3));
    sfc_chk sfc_chk_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .cs_n(sfc_link_if_i.cs_n),
        .sck(sfc_link_if_i.sck), .si(sfc_link_if_i.si), .so(sfc_link_if_i.so),
        .so_oe(sfc_link_if_i.so_oe), .hold_n(sfc_link_if_i.hold_n));
    // ----------------
    // bus and link tasks
    // ----------------
    task automatic complete_run();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        @(negedge mclk_i);
        d = rdata;
        @(posedge mclk_i);
    endtask
    // one byte per call; busy also spans the final select delay
    task automatic xfer(input logic [7:0] b, input logic last);
        logic [31:0] s;
        wr_reg(REG_DATA, {23'h0, last, b});
        for (int k = 0; k < 200; k++) begin
            rd_reg(REG_STATUS, s);
            if (s[0] === 1'b0) break;
        end
        if (s[0] !== 1'b0) begin
            n_mismatch++;
            complete_run();
        end
        rd_reg(REG_RX, s);
        rx = s[7:0];
    endtask
    task automatic frame(input logic [7:0] b [$]);
        foreach (b[k]) xfer(b[k], k == b.size() - 1);
    endtask
    // third byte checks that status repeats
    task automatic stat(input logic [7:0] exp);
        frame({OP_READ_STATUS, 8'h00, 8'h00});
        chk("status", exp, rx);
    endtask
    // ----------------
    // scenarios
    // ----------------
    task automatic t_wel();
        frame({OP_WRITE_EN});
        chk("wel", 8'h01, {7'h0, wel});
        chk("mode3", 8'h00, {7'h0, mode3});
        stat(8'h02);
        xfer(OP_READ_STATUS, 1'b0);
        wr_reg(REG_PINS, 32'h1);
        repeat (8) @(posedge mclk_i);
        wr_reg(REG_PINS, 32'h3);
        xfer(8'h00, 1'b1);
        chk("held", 8'h02, rx);
        frame({OP_WRITE_DIS});
        stat(8'h00);
    endtask
    task automatic t_id();
        frame({OP_READ_ID, 8'h00, 8'h00, 8'h00});
        chk("id", ID_SIZE, rx);
        frame({OP_ID_WAKE, 8'h00, 8'h00, 8'h00, 8'h00});
        chk("id2", ID_SECOND, rx);
        frame({OP_POWER_DOWN});
        chk("pdown", 8'h01, {7'h0, pdown});
        frame({OP_WRITE_EN});
        chk("wel", 8'h00, {7'h0, wel});
        frame({OP_ID_WAKE});
        chk("pdown", 8'h00, {7'h0, pdown});
    endtask
    task automatic t_erase();
        frame({OP_WRITE_EN});
        frame({OP_SMALL_ERASE_B, 8'hfc, 8'h00, 8'h00});
        chk("busy", 8'h01, {7'h0, busy});
        stat(8'h01);
        repeat (4200) @(posedge mclk_i);
        chk("busy", 8'h00, {7'h0, busy});
        stat(8'h00);
        frame({OP_READ, 8'hfc, 8'h00, 8'h00, 8'h00});
        chk("erased", ERASED_BYTE, rx);
    endtask
    task automatic t_prog();
        frame({OP_WRITE_EN});
        frame({OP_PROGRAM, 8'h00, 8'h00, 8'h10, 8'ha5});
        repeat (300) @(posedge mclk_i);
        frame({OP_READ, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h00});
        chk("next", 8'ha5, rx);
        frame({OP_FAST_READ, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00});
        chk("fast", 8'ha5, rx);
    endtask
    task automatic t_lock();
        frame({OP_WRITE_EN});
        frame({OP_WRITE_STATUS, 8'h80});
        repeat (30) @(posedge mclk_i);
        wr_reg(REG_PINS, 32'h0);
        repeat (10) @(posedge mclk_i);
        wr_reg(REG_PINS, 32'h2);
        frame({OP_WRITE_EN});
        frame({OP_WRITE_STATUS, 8'h00});
        repeat (30) @(posedge mclk_i);
        frame({OP_READ_STATUS, 8'h00});
        chk("lock", 8'h80, rx & 8'h80);
        wr_reg(REG_PINS, 32'h3);
        frame({OP_WRITE_EN});
        frame({OP_WRITE_STATUS, 8'h00});
        repeat (30) @(posedge mclk_i);
        stat(8'h00);
    endtask
    initial begin
        forever #4 mclk_i = ~mclk_i;
    end
    initial begin
        repeat (4) @(posedge mclk_i);
        resetn_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        t_wel();
        t_id();
        t_erase();
        t_prog();
        t_lock();
        complete_run();
    end
endmodule
